// ==== hdl/ccpts_dead_band.sv ====
`timescale 1ns/1ps
`default_nettype none
// Delays the rising edge of one output by a programmable count
module ccpts_dead_band
    import ccpts_pkg::*;
#(
    parameter int DW = 7
) (
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    input  wire logic          pwm_i,
    input  wire logic [DW-1:0] delay_i,
    output logic               out_o
);
    logic [DW-1:0] cnt_q, cnt_d;
    logic          out_q, out_d;

    // ************************************************************
    // Next state: count while input high, assert on reaching delay
    // ************************************************************
    always_comb begin
        cnt_d = cnt_q;
        out_d = out_q;
        if (!pwm_i) begin
            cnt_d = '0;
            out_d = 1'b0;             // Falling edge follows at once
        end else if (cnt_q >= delay_i) begin
            out_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    // Registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_q <= '0;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    // Short high phase never reaches the output
    assign out_o = out_q;

    delay_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !pwm_i |=> !out_q) else $error("output not dropped after input fell");
endmodule : ccpts_dead_band
`default_nettype wire

// ==== hdl/ccpts_pkg.sv ====
package ccpts_pkg;

    // ************************************************************
    // Register map (index on the plain register port)
    // ************************************************************
    localparam logic [5:0] UNIT_COUNT        = 6'h07;  // Units 4..10
    localparam logic [5:0] ADDR_CTRL_BASE    = 6'h00;  // Control regs 0x00..0x06
    localparam logic [5:0] ADDR_DLOW_BASE    = 6'h08;  // Data low bytes 0x08..0x0E
    localparam logic [5:0] ADDR_DHIGH_BASE   = 6'h10;  // Data high bytes 0x10..0x16
    localparam logic [5:0] ADDR_TSEL_A       = 6'h18;
    localparam logic [5:0] ADDR_TSEL_B       = 6'h19;
    localparam logic [5:0] ADDR_DEAD_BAND    = 6'h1A;
    localparam logic [5:0] ADDR_PERIOD       = 6'h1B;
    localparam logic [5:0] ADDR_DUTY         = 6'h1C;
    localparam logic [5:0] ADDR_BRIDGE_CTRL  = 6'h1D;
    localparam logic [5:0] ADDR_STATUS       = 6'h1E;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int TSA_U4_LSB  = 0;  // 2 bits
    localparam int TSA_U5_BIT  = 2;
    localparam int TSA_U6_BIT  = 3;
    localparam int TSA_U7_LSB  = 4;  // 2 bits
    localparam int TSB_U8_LSB  = 0;  // 2 bits
    localparam int TSB_U9_BIT  = 2;
    localparam int TSB_U10_BIT = 3;
    localparam int CTRL_PWM_BIT = 3; // Unit control: 1 = PWM group
    localparam int BRG_EN_BIT   = 0; // Bridge control: half-bridge enable

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic [6:0] RST_DEAD   = 7'h00;

    // ************************************************************
    // Timer codes
    // ************************************************************
    typedef enum logic [3:0] {
        CCPTS_TMR_NONE = 4'h0,
        CCPTS_TMR1 = 4'h1, CCPTS_TMR2 = 4'h2, CCPTS_TMR3 = 4'h3, CCPTS_TMR4 = 4'h4,
        CCPTS_TMR5 = 4'h5, CCPTS_TMR6 = 4'h6, CCPTS_TMR8 = 4'h8
    } ccpts_timer_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ccpts_bus_t;

endpackage : ccpts_pkg

// ==== hdl/ccpts_top.sv ====
// Contract
// - Each unit has a control register and 16-bit data register in two bytes.
// - Capture/compare uses timers 1,3,5; PWM uses timers 2,4,6,8.
// - Each unit's timer comes from its select field.
// - All units run together and may share a timer within one mode group.
// - Select register A holds units 4-7; register B holds units 8-10.
// - Unit 4 and unit 7 two-bit select maps per the timer tables.
// - Units 5 and 6 one-bit select maps to timers 1/5 and 2/4 or 2/2.
// - Units 8-10 use timer 1 for capture; PWM per their select codes.
// - Half-bridge drives PWM on output A and its complement on B.
// - Seven-bit dead band sets cycles before an output goes active.
// - Dead band longer than the active phase keeps that output inactive.
// - PWM timer counts to period then wraps; period resets to FFh.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ccpts_top
    import ccpts_pkg::*;
#(
    parameter int NUNITS = 7
) (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic [5:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    output logic      [27:0] unit_timer_o,     // 4-bit timer code per unit, unit 4 lowest
    output logic             bridge_output_a_o,
    output logic             bridge_output_b_o,
    output logic      [7:0]  pwm_count_o
);
    import ccpts_pkg::*;

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [7:0] ctrl_q [NUNITS];
    logic [7:0] ctrl_d [NUNITS];
    logic [7:0] dlow_q [NUNITS];
    logic [7:0] dlow_d [NUNITS];
    logic [7:0] dhigh_q[NUNITS];
    logic [7:0] dhigh_d[NUNITS];
    logic [7:0] tsel_a_q, tsel_a_d;
    logic [7:0] tsel_b_q, tsel_b_d;
    logic [6:0] dead_q,   dead_d;
    logic [7:0] period_q, period_d;
    logic [7:0] duty_q,   duty_d;
    logic [7:0] brg_q,    brg_d;
    logic [7:0] rdata_q,  rdata_d;
    logic [7:0] cnt_q,    cnt_d;
    logic       pwm_q,    pwm_d;
    ccpts_bus_t bus;

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // Index of a unit register inside a bank, or 7 if outside it
    function automatic logic [2:0] bank_index(input logic [5:0] a, input logic [5:0] base);
        logic [5:0] off;
        off = a - base;
        if (a >= base && off < UNIT_COUNT)
            bank_index = off[2:0];
        else
            bank_index = 3'h7;
    endfunction : bank_index

    // ************************************************************
    // Register writes and read mux
    // ************************************************************
    always_comb begin
        logic [2:0] ic, il, ih;
        ic = bank_index(bus.addr, ADDR_CTRL_BASE);
        il = bank_index(bus.addr, ADDR_DLOW_BASE);
        ih = bank_index(bus.addr, ADDR_DHIGH_BASE);
        for (int i = 0; i < NUNITS; i++) begin
            ctrl_d[i]  = ctrl_q[i];
            dlow_d[i]  = dlow_q[i];
            dhigh_d[i] = dhigh_q[i];
        end
        tsel_a_d = tsel_a_q;
        tsel_b_d = tsel_b_q;
        dead_d   = dead_q;
        period_d = period_q;
        duty_d   = duty_q;
        brg_d    = brg_q;
        rdata_d  = 8'h00;
        if (bus.wr) begin
            if (ic != 3'h7) ctrl_d[ic] = bus.wdata;
            if (il != 3'h7) dlow_d[il] = bus.wdata;
            if (ih != 3'h7) dhigh_d[ih] = bus.wdata;
            case (bus.addr)
                ADDR_TSEL_A:      tsel_a_d = bus.wdata;
                ADDR_TSEL_B:      tsel_b_d = {4'h0, bus.wdata[3:0]};
                ADDR_DEAD_BAND:   dead_d   = bus.wdata[6:0];
                ADDR_PERIOD:      period_d = bus.wdata;
                ADDR_DUTY:        duty_d   = bus.wdata;
                ADDR_BRIDGE_CTRL: brg_d    = {7'h00, bus.wdata[BRG_EN_BIT]};
                default: ;
            endcase
        end
        if (bus.rd) begin
            if (ic != 3'h7) rdata_d = ctrl_q[ic];
            if (il != 3'h7) rdata_d = dlow_q[il];
            if (ih != 3'h7) rdata_d = dhigh_q[ih];
            case (bus.addr)
                ADDR_TSEL_A:      rdata_d = tsel_a_q;
                ADDR_TSEL_B:      rdata_d = tsel_b_q;
                ADDR_DEAD_BAND:   rdata_d = {1'b0, dead_q};
                ADDR_PERIOD:      rdata_d = period_q;
                ADDR_DUTY:        rdata_d = duty_q;
                ADDR_BRIDGE_CTRL: rdata_d = brg_q;
                ADDR_STATUS:      rdata_d = {5'h00, bridge_output_b_o, bridge_output_a_o, pwm_q};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < NUNITS; i++) begin
                ctrl_q[i]  <= RST_BYTE;
                dlow_q[i]  <= RST_BYTE;
                dhigh_q[i] <= RST_BYTE;
            end
            tsel_a_q <= RST_BYTE;
            tsel_b_q <= RST_BYTE;
            dead_q   <= RST_DEAD;
            period_q <= RST_PERIOD;
            duty_q   <= RST_BYTE;
            brg_q    <= RST_BYTE;
            rdata_q  <= RST_BYTE;
        end else begin
            for (int i = 0; i < NUNITS; i++) begin
                ctrl_q[i]  <= ctrl_d[i];
                dlow_q[i]  <= dlow_d[i];
                dhigh_q[i] <= dhigh_d[i];
            end
            tsel_a_q <= tsel_a_d;
            tsel_b_q <= tsel_b_d;
            dead_q   <= dead_d;
            period_q <= period_d;
            duty_q   <= duty_d;
            brg_q    <= brg_d;
            rdata_q  <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

    // ************************************************************
    // Timer routing per unit
    // ************************************************************
    // Decodes select code and mode into a timer; reserved codes give none
    function automatic ccpts_timer_t route(input int unit, input logic [1:0] s, input logic pwm);
        ccpts_timer_t t;
        t = CCPTS_TMR_NONE;
        case (unit)
            4: case (s)
                2'b00: t = pwm ? CCPTS_TMR2 : CCPTS_TMR1;
                2'b01: t = pwm ? CCPTS_TMR4 : CCPTS_TMR3;
                2'b10: t = pwm ? CCPTS_TMR6 : CCPTS_TMR3;
                default: t = CCPTS_TMR_NONE;
            endcase
            5: t = s[0] ? (pwm ? CCPTS_TMR4 : CCPTS_TMR5) : (pwm ? CCPTS_TMR2 : CCPTS_TMR1);
            6: t = s[0] ? (pwm ? CCPTS_TMR2 : CCPTS_TMR5) : (pwm ? CCPTS_TMR2 : CCPTS_TMR1);
            7: case (s)
                2'b00: t = pwm ? CCPTS_TMR2 : CCPTS_TMR1;
                2'b01: t = pwm ? CCPTS_TMR4 : CCPTS_TMR5;
                2'b10: t = pwm ? CCPTS_TMR6 : CCPTS_TMR5;
                default: t = pwm ? CCPTS_TMR8 : CCPTS_TMR5;
            endcase
            8: case (s)
                2'b00: t = pwm ? CCPTS_TMR2 : CCPTS_TMR1;
                2'b01: t = pwm ? CCPTS_TMR4 : CCPTS_TMR1;
                2'b10: t = pwm ? CCPTS_TMR6 : CCPTS_TMR1;
                default: t = CCPTS_TMR_NONE;
            endcase
            9: t = pwm ? (s[0] ? CCPTS_TMR4 : CCPTS_TMR2) : CCPTS_TMR1;
            default: t = s[0] ? CCPTS_TMR_NONE : (pwm ? CCPTS_TMR2 : CCPTS_TMR1);
        endcase
        return t;
    endfunction : route

    // Each unit decoded on its own, so sharing a timer is free
    always_comb begin
        logic [1:0] sel [NUNITS];
        sel[0] = tsel_a_q[TSA_U4_LSB +: 2];
        sel[1] = {1'b0, tsel_a_q[TSA_U5_BIT]};
        sel[2] = {1'b0, tsel_a_q[TSA_U6_BIT]};
        sel[3] = tsel_a_q[TSA_U7_LSB +: 2];
        sel[4] = tsel_b_q[TSB_U8_LSB +: 2];
        sel[5] = {1'b0, tsel_b_q[TSB_U9_BIT]};
        sel[6] = {1'b0, tsel_b_q[TSB_U10_BIT]};
        for (int i = 0; i < NUNITS; i++)
            unit_timer_o[4*i +: 4] = route(i + 4, sel[i], ctrl_q[i][CTRL_PWM_BIT]);
    end

    // ************************************************************
    // PWM time base and half-bridge output stage
    // ************************************************************
    always_comb begin
        cnt_d = (cnt_q == period_q) ? 8'h00 : cnt_q + 8'h01;
        pwm_d = brg_q[BRG_EN_BIT] && (cnt_d < duty_q);
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_q <= 8'h00;
            pwm_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pwm_q <= pwm_d;
        end
    end

    assign pwm_count_o = cnt_q;

    // Separate delay chains so each output waits out the band
    ccpts_dead_band #(.DW(7)) u_band_a (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pwm_i   (pwm_q),
        .delay_i (dead_q),
        .out_o   (bridge_output_a_o)
    );

    ccpts_dead_band #(.DW(7)) u_band_b (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pwm_i   (brg_q[BRG_EN_BIT] & ~pwm_q),
        .delay_i (dead_q),
        .out_o   (bridge_output_b_o)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    // Time base: one step per cycle, back to zero after the period match
    wrap_count_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (cnt_q == period_q) |=> (cnt_q == 8'h00))
        else $error("timer did not wrap");
    count_step_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (cnt_q != period_q) |=> (cnt_q == $past(cnt_q) + 8'h01))
        else $error("timer skipped a count");
    period_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_i && addr_i == ADDR_PERIOD) |=> (period_q == $past(wdata_i)))
        else $error("period write lost");

    // Bridge pair: never both on, and a disabled stage stays quiet
    no_overlap_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !(bridge_output_a_o && bridge_output_b_o))
        else $error("bridge shoot-through");
    bridge_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !brg_q[BRG_EN_BIT] |=> !pwm_q)
        else $error("pwm active while bridge disabled");
    band_delay_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ($rose(pwm_q) && dead_q == 7'h02) |-> !bridge_output_a_o [*3])
        else $error("dead band too short");

    // Register port: read data only in the cycle after a read strobe
    tsel_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd_i && addr_i == ADDR_TSEL_A) |=> (rdata_o == $past(tsel_a_q)))
        else $error("select readback");
    read_idle_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !rd_i |=> (rdata_o == 8'h00))
        else $error("read data outside read cycle");

    // Routing spot checks, at least one per select style and mode group
    unit4_pwm_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (ctrl_q[0][CTRL_PWM_BIT] && tsel_a_q[1:0] == 2'b10) |-> (unit_timer_o[3:0] == 4'h6))
        else $error("unit 4 pwm route");
    unit4_cc_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (!ctrl_q[0][CTRL_PWM_BIT] && tsel_a_q[1:0] == 2'b01) |-> (unit_timer_o[3:0] == 4'h3))
        else $error("unit 4 capture route");
    unit5_pwm_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (ctrl_q[1][CTRL_PWM_BIT] && tsel_a_q[TSA_U5_BIT]) |-> (unit_timer_o[7:4] == 4'h4))
        else $error("unit 5 pwm route");
    unit6_pwm_a: assert property (@(posedge clk_i) disable iff (reset_i)
        ctrl_q[2][CTRL_PWM_BIT] |-> (unit_timer_o[11:8] == 4'h2))
        else $error("unit 6 pwm route");
    unit6_group_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !ctrl_q[2][CTRL_PWM_BIT] |-> (unit_timer_o[11:8] == 4'h1 || unit_timer_o[11:8] == 4'h5))
        else $error("unit 6 capture group");
    unit7_cc_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (!ctrl_q[3][CTRL_PWM_BIT] && tsel_a_q[5:4] != 2'b00) |-> (unit_timer_o[15:12] == 4'h5))
        else $error("unit 7 capture route");
    unit7_pwm_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (ctrl_q[3][CTRL_PWM_BIT] && tsel_a_q[5:4] == 2'b11) |-> (unit_timer_o[15:12] == 4'h8))
        else $error("unit 7 pwm route");
    unit8_cc_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (!ctrl_q[4][CTRL_PWM_BIT] && tsel_b_q[1:0] != 2'b11) |-> (unit_timer_o[19:16] == 4'h1))
        else $error("unit 8 capture route");
    unit9_cc_a: assert property (@(posedge clk_i) disable iff (reset_i)
        !ctrl_q[5][CTRL_PWM_BIT] |-> (unit_timer_o[23:20] == 4'h1))
        else $error("unit 9 capture route");
    unit9_pwm_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (ctrl_q[5][CTRL_PWM_BIT] && tsel_b_q[TSB_U9_BIT]) |-> (unit_timer_o[23:20] == 4'h4))
        else $error("unit 9 pwm route");
    unit10_pwm_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (ctrl_q[6][CTRL_PWM_BIT] && !tsel_b_q[TSB_U10_BIT]) |-> (unit_timer_o[27:24] == 4'h2))
        else $error("unit 10 pwm route");
endmodule : ccpts_top
`default_nettype wire

// ==== verification/ccpts_bridge_load.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Full-bridge power stage seen from the two bridge outputs
// ************************************************************
// Pins are taken as already set up as outputs by software
module ccpts_bridge_load (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        drive_a_i,
    input  wire logic        drive_b_i,
    output logic      [15:0] shoot_cnt_o
);
    logic hs_left;
    logic ls_left;
    logic hs_right;
    logic ls_right;
    // Diagonal switch pairs share one drive, so each leg sees A against B
    assign hs_left  = drive_a_i;
    assign ls_right = drive_a_i;
    assign ls_left  = drive_b_i;
    assign hs_right = drive_b_i;
    // Any cycle with both switches of one leg on would short the supply
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            shoot_cnt_o <= 16'h0000;
        end else if ((hs_left && ls_left) || (hs_right && ls_right)) begin
            shoot_cnt_o <= shoot_cnt_o + 16'h0001;
        end
    end
endmodule : ccpts_bridge_load
`default_nettype wire

// ==== verification/test_ccpts_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_ccpts_top;
    import ccpts_pkg::*;
    logic        clk_i   = 1'b0;
    logic        reset_i = 1'b1;
    logic [5:0]  addr_i  = 6'h00;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i    = 1'b0;
    logic        rd_i    = 1'b0;
    logic [7:0]  rdata_o;
    logic [27:0] unit_timer_o;
    logic        bridge_output_a_o;
    logic        bridge_output_b_o;
    logic [7:0]  pwm_count_o;
    logic [15:0] shoot_cnt;
    int          n_mismatch = 0;
    int          n_compared = 0;

    ccpts_top #(.NUNITS(7)) ccpts_top_i (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .unit_timer_o(unit_timer_o),
        .bridge_output_a_o(bridge_output_a_o), .bridge_output_b_o(bridge_output_b_o), .pwm_count_o(pwm_count_o));
    ccpts_bridge_load ccpts_bridge_load_i (.clk_i(clk_i), .reset_i(reset_i), .drive_a_i(bridge_output_a_o),
        .drive_b_i(bridge_output_b_o), .shoot_cnt_o(shoot_cnt));

    always #2.5 clk_i = ~clk_i;

    // ************************************************************
    // Expectations, bus cycles and comparisons
    // ************************************************************
    // Nibble k of the table is the timer for k = {pwm mode, select}; zero marks a reserved select
    function automatic logic [3:0] exp_code(input int u, input logic m, input logic [5:0] a, input logic [3:0] b);
        logic [1:0]  s;
        logic [31:0] t;
        case (u)
            0: begin s = a[1:0];        t = 32'h06420331; end
            1: begin s = {1'b0, a[2]};  t = 32'h00420051; end
            2: begin s = {1'b0, a[3]};  t = 32'h00220051; end
            3: begin s = a[5:4];        t = 32'h86425551; end
            4: begin s = b[1:0];        t = 32'h06420111; end
            5: begin s = {1'b0, b[2]};  t = 32'h00420011; end
            default: begin s = {1'b0, b[3]}; t = 32'h00020001; end
        endcase
        return t[{m, s} * 4 +: 4];
    endfunction : exp_code

    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_byte

    task automatic chk_code(input string n, input logic [3:0] e, input logic [3:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk_code

    task automatic chk_num(input string n, input int e, input int g);
        n_compared++;
        if (g != e) begin
            n_mismatch++;
            $display("[ERR] %s expected %0d seen %0d", n, e, g);
        end
    endtask : chk_num

    // Second edge drops the strobe, so back-to-back calls leave one idle cycle
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input string n, input logic [5:0] a, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 chk_byte(n, e, rdata_o);
    endtask : rd_chk

    // Mode bit alternates between neighbours so both groups share timers at once
    task automatic check_units(input logic [5:0] a, input logic [3:0] b, input logic m);
        for (int u = 0; u < 7; u++) chk_code("unit timer", exp_code(u, m ^ u[0], a, b), unit_timer_o[u*4 +: 4]);
    endtask : check_units

    // Per-period high time of each output from duty, period and dead band
    task automatic bridge_case(input logic [7:0] per, input logic [7:0] duty, input logic [6:0] dead, input logic en);
        int na;
        int nb;
        int ea;
        int eb;
        na = 0;
        nb = 0;
        wr_reg(ADDR_PERIOD, per);
        wr_reg(ADDR_DUTY, duty);
        wr_reg(ADDR_DEAD_BAND, {1'b0, dead});
        wr_reg(ADDR_BRIDGE_CTRL, {7'h00, en});
        // Long settle: a count above the new period may first run to its wrap
        repeat (300) @(posedge clk_i);
        repeat (per + 1) begin
            @(posedge clk_i);
            #1;
            if (bridge_output_a_o === 1'b1) na++;
            if (bridge_output_b_o === 1'b1) nb++;
        end
        ea = (en && duty > dead) ? duty - dead : 0;
        // Zero duty gives the complement no rising edge, so it stands high all period
        if (en && duty == 8'h00) eb = per + 1;
        else eb = (en && per + 1 - duty > dead) ? per + 1 - duty - dead : 0;
        chk_num("width a", ea, na);
        chk_num("width b", eb, nb);
    endtask : bridge_case

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // Cut a hang well beyond the expected run of some 7200 cycles
    initial begin
        #300000;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        logic [7:0] c;
        logic [7:0] p;
        logic [5:0] sa;
        logic [3:0] sb;
        void'($urandom(32'hDEC7A0F0));
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        // All control registers clear, so every unit sits in the capture group
        #1;
        for (int u = 0; u < 7; u++)
            chk_code("reset timer", exp_code(u, 1'b0, 6'h00, 4'h0), unit_timer_o[u*4 +: 4]);
        rd_chk("period reset", ADDR_PERIOD, RST_PERIOD);
        rd_chk("select a reset", ADDR_TSEL_A, 8'h00);
        for (int u = 0; u < 7; u++) begin
            c = 8'($urandom);
            wr_reg(ADDR_CTRL_BASE + 6'(u), c);
            wr_reg(ADDR_DLOW_BASE + 6'(u), ~c);
            wr_reg(ADDR_DHIGH_BASE + 6'(u), c ^ 8'h5A);
            rd_chk("control", ADDR_CTRL_BASE + 6'(u), c);
            rd_chk("data low", ADDR_DLOW_BASE + 6'(u), ~c);
            rd_chk("data high", ADDR_DHIGH_BASE + 6'(u), c ^ 8'h5A);
        end
        wr_reg(6'h07, 8'hA5);
        rd_chk("unmapped", 6'h07, 8'h00);
        rd_chk("unmapped", 6'h1F, 8'h00);
        wr_reg(ADDR_DEAD_BAND, 8'hFF);
        rd_chk("dead band", ADDR_DEAD_BAND, 8'h7F);
        // Every legal select code in both mode groups; reserved codes folded onto legal ones
        for (int i = 0; i < 128; i++) begin
            for (int u = 0; u < 7; u++) begin
                c = 8'($urandom);
                c[CTRL_PWM_BIT] = i[6] ^ u[0];
                wr_reg(ADDR_CTRL_BASE + 6'(u), c);
            end
            sa = 6'(i);
            if (sa[1:0] == 2'b11) sa[1:0] = 2'b10;
            sb = 4'(i);
            if (sb[1:0] == 2'b11) sb[1:0] = 2'b10;
            sb[TSB_U10_BIT] = 1'b0;
            wr_reg(ADDR_TSEL_A, {2'b00, sa});
            wr_reg(ADDR_TSEL_B, {4'hF, sb});
            @(posedge clk_i);
            #1 check_units(sa, sb, i[6]);
            rd_chk("select a", ADDR_TSEL_A, {2'b00, sa});
            rd_chk("select b", ADDR_TSEL_B, {4'h0, sb});
        end
        wr_reg(ADDR_PERIOD, 8'h06);
        repeat (300) @(posedge clk_i);
        #1 p = pwm_count_o;
        repeat (20) begin
            @(posedge clk_i);
            #1 chk_byte("count", (p == 8'h06) ? 8'h00 : p + 8'h01, pwm_count_o);
            p = pwm_count_o;
        end
        bridge_case(8'd9, 8'd4, 7'd0, 1'b1);
        bridge_case(8'd9, 8'd4, 7'd3, 1'b1);
        bridge_case(8'd9, 8'd4, 7'd5, 1'b1);
        bridge_case(8'd9, 8'd0, 7'd2, 1'b1);
        rd_chk("status", ADDR_STATUS, 8'h04);
        bridge_case(8'd9, 8'd6, 7'd2, 1'b1);
        bridge_case(8'd9, 8'd9, 7'd0, 1'b1);
        bridge_case(8'd20, 8'd10, 7'd127, 1'b1);
        bridge_case(8'd9, 8'd4, 7'd2, 1'b0);
        repeat (4) begin
            p = 8'd5 + 8'($urandom % 12);
            bridge_case(p, 8'($urandom % (p + 1)), 7'($urandom % (p + 2)), 1'b1);
        end
        chk_num("shoot-through", 0, (shoot_cnt === 16'h0000) ? 0 : 1);
        wrap_up();
    end
endmodule : test_ccpts_top
`default_nettype wire
